// *** rtl/pgbt_defs.svh ***
// Purpose: constants for the power gating and bias trim register bank
// Assumes: Avalon-MM word addressing of byte offsets
// Notes: offsets are register indices, byte address = 4 * index
`ifndef PGBT_DEFS_SVH
`define PGBT_DEFS_SVH
// =====================================================================
// register map
`define PGBT_IDX_PWR 4'h1
`define PGBT_IDX_TRIM 4'h2
`define PGBT_ADDR_W 4
// =====================================================================
// power gating fields
`define PGBT_PWR_MASTER 7
`define PGBT_PWR_CLAMP 6
`define PGBT_PWR_REF2 5
`define PGBT_PWR_REF1 4
`define PGBT_PWR_AMP2 3
`define PGBT_PWR_AMP1 2
`define PGBT_PWR_ADC2 1
`define PGBT_PWR_ADC1 0
`define PGBT_PWR_RST 8'h00
// =====================================================================
// bias trim fields
`define PGBT_TRIM1_HI 5
`define PGBT_TRIM1_LO 3
`define PGBT_TRIM2_HI 2
`define PGBT_TRIM2_LO 0
`define PGBT_TRIM_DFLT 3'h4
`define PGBT_TRIM_MASK 8'h3f
`endif

// *** rtl/pgbt_pkg.sv ***
// Purpose: types for the power gating and bias trim register bank
// Assumes: nothing
// Notes: none
package pgbt_pkg;
  typedef enum logic [2:0] {
    PGBT_IDLE = 3'b001,
    PGBT_ACK = 3'b010,
    PGBT_DONE = 3'b100
  } pgbt_st_t;
endpackage

// *** rtl/pgbt_gate.sv ***
// Purpose: derive power-down levels from the gating register
// Assumes: synchronous reset-free combinational use inside top
// Notes: master bit overrides the individual bits
`timescale 1ns/10ps
`include "pgbt_defs.svh"
module pgbt_gate (
  input wire logic [7:0] pwr_reg,
  output logic [6:0] pd_out
);
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_bit
      assign pd_out[gi] = pwr_reg[`PGBT_PWR_MASTER] | pwr_reg[gi];
    end
  endgenerate
endmodule // pgbt_gate

// *** rtl/pgbt_regs.sv ***
// Purpose: power gating and bias trim registers on Avalon-MM
// Assumes: clk_sys 125 MHz, rst_n async active low
// Notes: one wait cycle on an access that starts in idle, two if it starts in done, unmapped reads return zero
`timescale 1ns/10ps
`include "pgbt_defs.svh"
// Operation
// [RL1] master bit set forces every power-down output high regardless of others
// [RL2] bit 6 powers down the clamp voltage driver when one
// [RL3] bits 5 and 4 power down channel 2 and 1 reference buffers
// [RL4] bits 3 and 2 power down channel 2 and 1 gain amplifiers
// [RL5] bits 1 and 0 power down channel 2 and 1 converters
// [RL6] host writes baseline values after power-up before relying on device
// [RL7] trim bits 5:3 hold stage one current code, default 100
// [RL8] trim bits 2:0 hold stage two current code, default 100
// [RL9] trim bits 7 and 6 ignore writes and read zero
module pgbt_regs import pgbt_pkg::*; #(
  parameter int ADDR_W = `PGBT_ADDR_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic clamp_voltage_driver_pd,
  output logic ref_buf2_pd,
  output logic ref_buf1_pd,
  output logic gain_amplifier2_pd,
  output logic gain_amplifier1_pd,
  output logic adc2_pd,
  output logic adc1_pd,
  output logic [2:0] gain_amplifier_trim1,
  output logic [2:0] gain_amplifier_trim2
);
  if (ADDR_W < 2) begin : g_bad_addr_w
    $error("ADDR_W too small for the register map");
  end

  // =====================================================================
  // reset release
  logic rst_s1_ff, rst_s2_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire logic rst_i_n = rst_s2_ff;

  // =====================================================================
  // state
  typedef struct packed {
    pgbt_st_t st;
    logic [7:0] pwr;
    logic [7:0] trim;
    logic [31:0] rdata;
    logic wait_n;
    logic [6:0] pd;
  } pgbt_state_t;
  pgbt_state_t cur_ff, nxt_cur;

  localparam pgbt_state_t RST_VAL = '{st: PGBT_IDLE, pwr: `PGBT_PWR_RST,
    trim: {2'b00, `PGBT_TRIM_DFLT, `PGBT_TRIM_DFLT}, rdata: 32'h0000_0000,
    wait_n: 1'b0, pd: 7'h00};

  logic [6:0] pd_comb;
  pgbt_gate u_gate (
    .pwr_reg(cur_ff.pwr),
    .pd_out(pd_comb)
  );

  wire logic hit_pwr = avs_address == ADDR_W'(`PGBT_IDX_PWR);
  wire logic hit_trim = avs_address == ADDR_W'(`PGBT_IDX_TRIM);

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.pd = pd_comb; // RL1
    nxt_cur.wait_n = 1'b0;
    case (cur_ff.st)
      PGBT_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_cur.st = PGBT_ACK;
          nxt_cur.wait_n = 1'b1;
          nxt_cur.rdata = 32'h0000_0000;
          if (avs_read && hit_pwr) nxt_cur.rdata = {24'h00_0000, cur_ff.pwr};
          if (avs_read && hit_trim) begin
            nxt_cur.rdata = {24'h00_0000, cur_ff.trim & `PGBT_TRIM_MASK}; // RL9
          end
        end
      end
      PGBT_ACK: begin
        // write lands on the edge that completes the transfer
        nxt_cur.st = PGBT_DONE;
        if (avs_write && avs_byteenable[0] && hit_pwr) begin
          nxt_cur.pwr = avs_writedata[7:0]; // RL2 RL3 RL4 RL5
        end
        if (avs_write && avs_byteenable[0] && hit_trim) begin
          nxt_cur.trim = avs_writedata[7:0] & `PGBT_TRIM_MASK; // RL7 RL8 RL9
        end
      end
      PGBT_DONE: nxt_cur.st = PGBT_IDLE;
      default: nxt_cur.st = PGBT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_i_n) begin
    if (!rst_i_n) cur_ff <= RST_VAL;
    else cur_ff <= nxt_cur;
  end

  // =====================================================================
  // outputs
  assign avs_readdata = cur_ff.rdata;
  assign avs_waitrequest = ~cur_ff.wait_n;
  assign clamp_voltage_driver_pd = cur_ff.pd[`PGBT_PWR_CLAMP]; // RL2
  assign ref_buf2_pd = cur_ff.pd[`PGBT_PWR_REF2]; // RL3
  assign ref_buf1_pd = cur_ff.pd[`PGBT_PWR_REF1]; // RL3
  assign gain_amplifier2_pd = cur_ff.pd[`PGBT_PWR_AMP2]; // RL4
  assign gain_amplifier1_pd = cur_ff.pd[`PGBT_PWR_AMP1]; // RL4
  assign adc2_pd = cur_ff.pd[`PGBT_PWR_ADC2]; // RL5
  assign adc1_pd = cur_ff.pd[`PGBT_PWR_ADC1]; // RL5
  assign gain_amplifier_trim1 = cur_ff.trim[`PGBT_TRIM1_HI:`PGBT_TRIM1_LO]; // RL7
  assign gain_amplifier_trim2 = cur_ff.trim[`PGBT_TRIM2_HI:`PGBT_TRIM2_LO]; // RL8

  // =====================================================================
  // checks
  sequence s_wr_pwr;
    avs_write && !avs_waitrequest && hit_pwr && avs_byteenable[0];
  endsequence
  sequence s_wr_trim;
    avs_write && !avs_waitrequest && hit_trim && avs_byteenable[0];
  endsequence

  a_master_all_pd: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // RL1
    $past(cur_ff.pwr[7]) |-> (&cur_ff.pd)) else $error("master did not force power-down");
  a_clamp_pd: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // RL2
    s_wr_pwr |-> ##2 clamp_voltage_driver_pd == ($past(avs_writedata[7], 2)
    | $past(avs_writedata[6], 2))) else $error("clamp power-down wrong");
  a_ref_buf_pd: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // RL3
    s_wr_pwr ##1 !cur_ff.pwr[7] |-> ##1 ref_buf2_pd == $past(cur_ff.pwr[5])
    && ref_buf1_pd == $past(cur_ff.pwr[4])) else $error("reference buffer wrong");
  a_amp_pd: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // RL4
    !cur_ff.pwr[7] |=> gain_amplifier2_pd == $past(cur_ff.pwr[3])
    && gain_amplifier1_pd == $past(cur_ff.pwr[2])) else $error("amplifier gating wrong");
  a_adc_pd: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // RL5
    !cur_ff.pwr[7] |=> adc2_pd == $past(cur_ff.pwr[1])
    && adc1_pd == $past(cur_ff.pwr[0])) else $error("converter gating wrong");
  a_trim_one: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // RL7
    s_wr_trim |=> gain_amplifier_trim1 == $past(avs_writedata[5:3]))
    else $error("stage one trim not stored");
  a_trim_two: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // RL8
    s_wr_trim |=> gain_amplifier_trim2 == $past(avs_writedata[2:0]))
    else $error("stage two trim not stored");
  a_trim_unused: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // RL9
    avs_read && !avs_waitrequest && hit_trim |-> avs_readdata[31:6] == 26'h0)
    else $error("unused trim bits not zero");
  a_wait_once: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
    (avs_read || avs_write) && avs_waitrequest && cur_ff.st == PGBT_IDLE
    |=> !avs_waitrequest) else $error("slave did not answer in one cycle");

  // =====================================================================
  // checks: handshake spacing and read data
  sequence s_rd_ack;
    avs_read && !avs_waitrequest;
  endsequence
  sequence s_two_busy;
    avs_waitrequest ##1 avs_waitrequest;
  endsequence

  // answer stands one cycle, then two busy cycles
  a_ack_spacing: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
    !avs_waitrequest |=> s_two_busy) else $error("acknowledge spacing wrong");
  // answer only to a request taken the edge before
  a_ack_has_req: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
    !avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("acknowledge without a request");
  a_rd_pwr_data: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
    s_rd_ack ##0 hit_pwr |-> avs_readdata == {24'h00_0000, cur_ff.pwr})
    else $error("gating register read back wrong");
  a_rd_trim_data: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // RL7 RL8
    s_rd_ack ##0 hit_trim |-> avs_readdata[5:0] == cur_ff.trim[5:0])
    else $error("trim register read back wrong");
  // unmapped index reads as zero
  a_rd_unmapped: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
    s_rd_ack ##0 (!hit_pwr && !hit_trim) |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // =====================================================================
  // checks: unused trim bits stay zero, stored bytes change only by a landing write
  a_trim_top_zero: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // RL9
    cur_ff.trim[7:6] == 2'h0) else $error("unused trim bits were stored");
  a_pwr_write_only: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
    !(avs_write && !avs_waitrequest && hit_pwr && avs_byteenable[0])
    |=> $stable(cur_ff.pwr)) else $error("gating register changed without a write");
  a_trim_write_only: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
    !(avs_write && !avs_waitrequest && hit_trim && avs_byteenable[0])
    |=> $stable(cur_ff.trim)) else $error("trim register changed without a write");
  // lane 0 off: nothing lands
  a_lane0_ignored: assert property (@(posedge clk_sys) disable iff (!rst_i_n)
    avs_write && !avs_waitrequest && !avs_byteenable[0]
    |=> $stable(cur_ff.pwr) && $stable(cur_ff.trim)) else $error("write without lane 0 landed");

  // =====================================================================
  // checks: power-down levels per bit
  // master bit forces every output on the next edge
  a_master_ports: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // RL1
    $rose(cur_ff.pwr[`PGBT_PWR_MASTER]) |=> clamp_voltage_driver_pd && ref_buf2_pd
    && ref_buf1_pd && gain_amplifier2_pd && gain_amplifier1_pd && adc2_pd && adc1_pd)
    else $error("master bit did not reach every output");
  // each bit follows master or its own bit
  genvar ci;
  generate
    for (ci = 0; ci < 7; ci++) begin : g_pd_chk
      a_pd_bit_level: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // RL1
        cur_ff.pd[ci] == ($past(cur_ff.pwr[`PGBT_PWR_MASTER]) | $past(cur_ff.pwr[ci])))
        else $error("power-down level does not follow the gating bits");
    end
  endgenerate
endmodule // pgbt_regs

// *** sim/test_pgbt_regs.sv ***
// Purpose: self-checking bench for the power gating and bias trim registers
// Assumes: slave answers each access by dropping waitrequest
// Notes: rows hold index, write value, readback and expected control levels
`timescale 1ns/10ps
module test_pgbt_regs;
  logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [6:0] pd;
  logic [2:0] t1, t2;
  logic [32:0] rows [0:13];
  int n_fail, cmp_count;
  pgbt_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .clamp_voltage_driver_pd(pd[6]),
    .ref_buf2_pd(pd[5]), .ref_buf1_pd(pd[4]), .gain_amplifier2_pd(pd[3]),
    .gain_amplifier1_pd(pd[2]), .adc2_pd(pd[1]), .adc1_pd(pd[0]),
    .gain_amplifier_trim1(t1), .gain_amplifier_trim2(t2));
  // =====================================================================
  // clock, watchdog, checks
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    summarize();
  end
  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic see(input logic [12:0] e);
    chk({19'h0, pd, t1, t2}, {19'h0, e});
  endtask
  // =====================================================================
  // bus master: hold until waitrequest low, release after that edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
      output logic [31:0] r);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h00_0000, d};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // =====================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    rows = '{{4'h2, 8'hff, 8'h3f, 13'h003f}, {4'h2, 8'h00, 8'h00, 13'h0000},
      {4'h2, 8'hde, 8'h1e, 13'h001e}, {4'h1, 8'h40, 8'h40, 13'h101e},
      {4'h1, 8'h20, 8'h20, 13'h081e}, {4'h1, 8'h10, 8'h10, 13'h041e},
      {4'h1, 8'h08, 8'h08, 13'h021e}, {4'h1, 8'h04, 8'h04, 13'h011e},
      {4'h1, 8'h02, 8'h02, 13'h009e}, {4'h1, 8'h01, 8'h01, 13'h005e},
      {4'h1, 8'h80, 8'h80, 13'h1fde}, {4'h1, 8'h85, 8'h85, 13'h1fde},
      {4'h3, 8'hff, 8'h00, 13'h1fde}, {4'h1, 8'h00, 8'h00, 13'h001e}};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    see(13'h0024);
    acc(1'b0, 4'h2, 8'h00, q);
    chk(q, 32'h0000_0024);
    acc(1'b1, 4'h1, 8'h00, q);
    acc(1'b1, 4'h2, 8'h24, q);
    foreach (rows[i]) begin
      acc(1'b1, rows[i][32:29], rows[i][28:21], q);
      acc(1'b0, rows[i][32:29], 8'h00, q);
      chk(q, {24'h00_0000, rows[i][20:13]});
      see(rows[i][12:0]);
    end
    // lane 0 disabled: write must not land
    avs_byteenable <= 4'he;
    acc(1'b1, 4'h2, 8'h3f, q);
    avs_byteenable <= 4'hf;
    acc(1'b0, 4'h2, 8'h00, q);
    chk(q, 32'h0000_001e);
    // second reset in mid-run with master set
    acc(1'b1, 4'h1, 8'h85, q);
    acc(1'b0, 4'h1, 8'h00, q);
    chk(q, 32'h0000_0085);
    see(13'h1fde);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    see(13'h0024);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    acc(1'b0, 4'h1, 8'h00, q);
    chk(q, 32'h0000_0000);
    summarize();
  end
endmodule // test_pgbt_regs
